// [verilog/ddm_pkg.sv]
package ddm_pkg;

  // ==========================================================
  // local register offsets
  localparam logic [15:0] PTR_ADDR_BASE = 16'h6000;
  localparam logic [15:0] PTR_ADDR_LAST = 16'h601f;
  localparam logic [15:0] PTR_DATA_BASE = 16'h6080;
  localparam logic [15:0] PTR_DATA_LAST = 16'h609f;
  localparam logic [15:0] REG_TIMEOUT   = 16'h6100;
  localparam logic [15:0] REG_ACT_A     = 16'h6101;
  localparam logic [15:0] REG_SPD_A     = 16'h6102;
  localparam logic [15:0] REG_DELAY     = 16'h6110;
  localparam logic [15:0] REG_REINIT    = 16'h6111;
  localparam logic [15:0] REG_VERSION   = 16'h6112;
  localparam logic [15:0] REG_ACT_B     = 16'he101;
  localparam logic [15:0] REG_SPD_B     = 16'he102;
  localparam int          PTR_SLOTS     = 32;

  // ==========================================================
  // address map landmarks
  localparam logic [15:0] HOLE_LO      = 16'h0600;
  localparam logic [15:0] HOLE_HI      = 16'h5fff;
  localparam logic [15:0] LOCAL_HI     = 16'h6112;
  localparam logic [15:0] A_HIGH_LO    = 16'h7000;
  localparam logic [15:0] B_DIRECT_LO  = 16'hf000;
  localparam logic [15:0] HALF_MASK    = 16'h7fff;
  localparam logic [15:0] HALF_BIT     = 16'h8000;

  // ==========================================================
  // value limits and defaults
  localparam logic [15:0] TIMEOUT_DEF  = 16'h2710;
  localparam logic [15:0] TIMEOUT_MIN  = 16'h0064;
  localparam logic [15:0] TIMEOUT_MAX  = 16'hea60;
  localparam logic [15:0] DELAY_MAX    = 16'h07d0;
  localparam logic [15:0] SPD_MAX      = 16'h000f;
  localparam logic [15:0] ACT_MAX      = 16'h0004;
  localparam logic [15:0] KEY_RESET    = 16'h5a5a;
  localparam logic [15:0] KEY_DEFAULTS = 16'hfeba;
  localparam logic [15:0] COIL_ON      = 16'hff00;
  localparam logic [15:0] COIL_OFF     = 16'h0000;

  // ==========================================================
  // exception codes
  localparam logic [7:0] EXC_NONE  = 8'h00;
  localparam logic [7:0] EXC_ADDR  = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_FAIL  = 8'h04;

  // ==========================================================
  // drive communication numbers kept in the offline cache, plus the end of the RAM-only range
  localparam logic [15:0] COMM_CMD      = 16'hfa00;
  localparam logic [15:0] COMM_FREQ     = 16'hfa01;
  localparam logic [15:0] COMM_RAM_LAST = 16'hfa02;
  localparam logic [15:0] COMM_FOUT     = 16'hfd00;
  localparam logic [15:0] COMM_STATUS   = 16'hfe01;
  localparam logic [15:0] COMM_CURRENT  = 16'hfe03;
  localparam logic [15:0] COMM_VOLTAGE  = 16'hfe05;
  localparam int          CACHE_SLOTS   = 6;
  localparam logic [2:0]  SLOT_CMD      = 3'h0;
  localparam logic [2:0]  SLOT_STATUS   = 3'h3;
  localparam logic [2:0]  SLOT_NONE     = 3'h6;

  // ==========================================================
  // coil addresses
  localparam logic [15:0] WCOIL_LAST  = 16'h001f;
  localparam logic [15:0] RCOIL_BASE  = 16'h0064;
  localparam logic [15:0] RCOIL_LAST  = 16'h0083;
  localparam logic [15:0] RCOIL_LINK_A = 16'h0073;
  localparam logic [3:0]  LINK_BIT    = 4'hf;

  typedef enum logic [1:0] {REQ_HREAD, REQ_HWRITE, REQ_CREAD, REQ_CWRITE} ddm_req_t;
  typedef enum logic [1:0] {DRV_READ, DRV_WRITE_EE, DRV_WRITE_RAM} ddm_drv_cmd_t;
  typedef enum logic [2:0] {ACT_NONE, ACT_DECEL, ACT_COAST, ACT_TRIP, ACT_PRESET} ddm_act_t;
  typedef enum logic {ST_IDLE, ST_DRIVE} ddm_state_t;

endpackage : ddm_pkg

// [verilog/ddm_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module ddm_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } ddm_sync_state_t;

  ddm_sync_state_t q;
  ddm_sync_state_t d;

  // ==========================================================
  // three stages; a bit moves only once stages two and three agree
  always_comb begin
    d    = q;
    d.s1 = i_async;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_level = q.lvl;

endmodule : ddm_sync

`default_nettype wire

// [verilog/ddm_mapper.sv]
`timescale 1ns/10ps
`default_nettype none

// How it works
// - only holding registers and coils served
// - lower half addresses go to drive A
// - upper half addresses go to drive B
// - drive A high numbers set bit 15
// - drive B low numbers clear bit 15
// - drive B high numbers map unchanged
// - local registers never forwarded to drives
// - 32 pointers, zero default, range checked
// - pointer data accesses the pointed register
// - timeout 100 to 60000, default 10000
// - action codes none, decel, coast, trip, preset
// - drive A preset 0-15, only with action 4
// - drive B own action and preset registers
// - response delay 0 to 2000, default 0
// - command registers use RAM-only write
// - overlimit frequency write still acknowledged
// - missing register or coil gives exception 02
// - invalid written data gives exception 03
// - offline coils hold; link coils show state
// - offline drive gives 04 except reads of cached six
// - write coils map onto command word bits
// - read coils map onto status word bits
module ddm_mapper
  import ddm_pkg::*;
#(
  parameter int         PTR_COUNT   = 32,
  parameter logic [7:0] FW_VERSION  = 8'h01,  // arbitrary value
  parameter logic [7:0] FW_REVISION = 8'h00   // arbitrary value
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic         i_req_valid,
  input  wire ddm_req_t     i_req_kind,
  input  wire logic [15:0]  i_req_addr,
  input  wire logic [15:0]  i_req_wdata,
  output logic              o_req_ready,
  output logic              o_rsp_valid,
  output logic [15:0]       o_rsp_data,
  output logic [7:0]        o_rsp_exc,
  output logic              o_drv_valid,
  output logic              o_drv_sel,
  output ddm_drv_cmd_t      o_drv_cmd,
  output logic [15:0]       o_drv_comm,
  output logic [15:0]       o_drv_wdata,
  input  wire logic         i_drv_done,
  input  wire logic [15:0]  i_drv_rdata,
  input  wire logic         i_drv_err,
  input  wire logic [1:0]   i_drv_online,
  output logic              o_reinit,
  output logic [15:0]       o_timeout_ms,
  output logic [15:0]       o_resp_delay_ms,
  output ddm_act_t          o_action_a,
  output ddm_act_t          o_action_b,
  output logic [3:0]        o_preset_a,
  output logic [3:0]        o_preset_b
);

  if (PTR_COUNT < 1 || PTR_COUNT > PTR_SLOTS) begin : g_bad_count
    $error("PTR_COUNT must lie between 1 and 32");
  end

  typedef struct packed {
    ddm_state_t                              state;
    ddm_req_t                                req_kind;
    logic [15:0]                             req_addr;
    logic [15:0]                             req_wdata;
    logic [15:0]                             eff;
    logic                                    rsp_valid;
    logic [15:0]                             rsp_data;
    logic [7:0]                              rsp_exc;
    logic                                    drv_sel;
    ddm_drv_cmd_t                            drv_cmd;
    logic [15:0]                             drv_comm;
    logic [15:0]                             drv_wdata;
    logic                                    reinit;
    logic [PTR_SLOTS-1:0][15:0]              ptr;
    logic [15:0]                             timeout;
    logic [15:0]                             delay;
    ddm_act_t [1:0]                          act;
    logic [1:0][3:0]                         spd;
    logic [1:0][CACHE_SLOTS-1:0][15:0]       cache;
  } ddm_state_q_t;

  ddm_state_q_t q;
  ddm_state_q_t d;
  logic [1:0]   w_online;
  logic         w_pdata;
  logic         w_pidx_ok;
  logic [15:0]  w_eff;

  // ==========================================================
  // helpers
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_range

  function automatic logic [15:0] drive_comm(input logic [15:0] a);
    if (!a[15]) begin
      return (a >= A_HIGH_LO) ? (a | HALF_BIT) : a;
    end
    return (a >= B_DIRECT_LO) ? a : (a & HALF_MASK);
  endfunction : drive_comm

  function automatic logic [2:0] cache_slot(input logic [15:0] c);
    case (c)
      COMM_CMD:     return 3'h0;
      COMM_FREQ:    return 3'h1;
      COMM_FOUT:    return 3'h2;
      COMM_STATUS:  return 3'h3;
      COMM_CURRENT: return 3'h4;
      COMM_VOLTAGE: return 3'h5;
      default:      return SLOT_NONE;
    endcase
  endfunction : cache_slot

  function automatic logic ptr_forbidden(input logic [15:0] v);
    return in_range(v, PTR_ADDR_BASE, PTR_ADDR_LAST) || in_range(v, PTR_DATA_BASE, PTR_DATA_LAST);
  endfunction : ptr_forbidden

  ddm_sync #(
    .WIDTH (2)
  ) u_online_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_drv_online),
    .o_level (w_online)
  );

  // pointer data slots redirect through their pointer
  assign w_pdata   = in_range(i_req_addr, PTR_DATA_BASE, PTR_DATA_LAST);
  assign w_pidx_ok = {1'b0, i_req_addr[4:0]} < 6'(PTR_COUNT);
  assign w_eff     = w_pdata ? q.ptr[i_req_addr[4:0]] : i_req_addr;

  // ==========================================================
  // request decode and drive sequencing
  always_comb begin
    logic         wr;
    logic         fwd;
    logic         sel;
    logic [15:0]  comm;
    logic [15:0]  fdata;
    logic [15:0]  coff;
    logic [2:0]   slot;
    wr    = (i_req_kind == REQ_HWRITE);
    fwd   = 1'b0;
    sel   = w_eff[15];
    comm  = drive_comm(w_eff);
    fdata = i_req_wdata;
    coff  = i_req_addr - RCOIL_BASE;
    slot  = cache_slot(comm);
    d           = q;
    d.rsp_valid = 1'b0;
    d.reinit    = 1'b0;
    case (q.state)
      ST_IDLE: begin
        if (i_req_valid) begin
          d.req_kind  = i_req_kind;
          d.req_addr  = i_req_addr;
          d.req_wdata = i_req_wdata;
          d.eff       = w_eff;
          d.rsp_valid = 1'b1;
          d.rsp_exc   = EXC_NONE;
          d.rsp_data  = '0;
          case (i_req_kind)
            REQ_HREAD, REQ_HWRITE: begin
              if (w_pdata && !w_pidx_ok) begin
                d.rsp_exc = EXC_ADDR;
              end else if (in_range(w_eff, PTR_ADDR_BASE, PTR_ADDR_LAST)) begin
                if ({1'b0, w_eff[4:0]} >= 6'(PTR_COUNT)) begin
                  d.rsp_exc = EXC_ADDR;
                end else if (!wr) begin
                  d.rsp_data = q.ptr[w_eff[4:0]];
                end else if (ptr_forbidden(i_req_wdata)) begin
                  d.rsp_exc = EXC_VALUE;
                end else begin
                  d.ptr[w_eff[4:0]] = i_req_wdata;
                end
              end else if (w_eff == REG_TIMEOUT) begin
                if (!wr) begin
                  d.rsp_data = q.timeout;
                end else if (in_range(i_req_wdata, TIMEOUT_MIN, TIMEOUT_MAX)) begin
                  d.timeout = i_req_wdata;
                end else begin
                  d.rsp_exc = EXC_VALUE;
                end
              end else if (w_eff == REG_ACT_A || w_eff == REG_ACT_B) begin
                if (!wr) begin
                  d.rsp_data = {13'h0000, q.act[sel]};
                end else if (i_req_wdata <= ACT_MAX) begin
                  d.act[sel] = ddm_act_t'(i_req_wdata[2:0]);
                end else begin
                  d.rsp_exc = EXC_VALUE;
                end
              end else if (w_eff == REG_SPD_A || w_eff == REG_SPD_B) begin
                if (!wr) begin
                  d.rsp_data = {12'h000, q.spd[sel]};
                end else if (i_req_wdata <= SPD_MAX) begin
                  d.spd[sel] = i_req_wdata[3:0];
                end else begin
                  d.rsp_exc = EXC_VALUE;
                end
              end else if (w_eff == REG_DELAY) begin
                if (!wr) begin
                  d.rsp_data = q.delay;
                end else if (i_req_wdata <= DELAY_MAX) begin
                  d.delay = i_req_wdata;
                end else begin
                  d.rsp_exc = EXC_VALUE;
                end
              end else if (w_eff == REG_REINIT) begin
                if (!wr) begin
                  d.rsp_data = '0;
                end else if (i_req_wdata == KEY_RESET) begin
                  d.reinit = 1'b1;
                end else if (i_req_wdata == KEY_DEFAULTS) begin
                  d.reinit  = 1'b1;
                  d.ptr     = '0;
                  d.timeout = TIMEOUT_DEF;
                  d.delay   = '0;
                  d.act[0]  = ACT_NONE;
                  d.act[1]  = ACT_NONE;
                  d.spd     = '0;
                end else begin
                  d.rsp_exc = EXC_VALUE;
                end
              end else if (w_eff == REG_VERSION) begin
                if (wr) begin
                  d.rsp_exc = EXC_ADDR;
                end else begin
                  d.rsp_data = {FW_VERSION, FW_REVISION};
                end
              end else if (in_range(w_eff, HOLE_LO, HOLE_HI) ||
                           in_range(w_eff, PTR_ADDR_BASE, LOCAL_HI)) begin
                d.rsp_exc = EXC_ADDR;
              end else if (!w_online[sel]) begin
                if (!wr && slot != SLOT_NONE) begin
                  d.rsp_data = q.cache[sel][slot];
                end else begin
                  d.rsp_exc = EXC_FAIL;
                end
              end else begin
                fwd = 1'b1;
              end
            end
            REQ_CWRITE: begin
              sel  = i_req_addr[4];
              comm = COMM_CMD;
              if (i_req_addr > WCOIL_LAST) begin
                d.rsp_exc = EXC_ADDR;
              end else if (i_req_wdata != COIL_ON && i_req_wdata != COIL_OFF) begin
                d.rsp_exc = EXC_VALUE;
              end else if (!w_online[sel]) begin
                d.rsp_exc = EXC_FAIL;
              end else begin
                // reserved bits pass like any other
                fdata                     = q.cache[sel][SLOT_CMD];
                fdata[i_req_addr[3:0]]    = (i_req_wdata == COIL_ON);
                fwd                       = 1'b1;
              end
            end
            REQ_CREAD: begin
              if (!in_range(i_req_addr, RCOIL_BASE, RCOIL_LAST)) begin
                d.rsp_exc = EXC_ADDR;
              end else if (coff[3:0] == LINK_BIT) begin
                d.rsp_data = {15'h0000, w_online[coff[4]]};
              end else begin
                // served from cache, so offline coils hold their last value
                d.rsp_data = {15'h0000, q.cache[coff[4]][SLOT_STATUS][coff[3:0]]};
              end
            end
            default: d.rsp_exc = EXC_ADDR;
          endcase
          if (fwd) begin
            d.rsp_valid = 1'b0;
            d.state     = ST_DRIVE;
            d.drv_sel   = sel;
            d.drv_comm  = comm;
            d.drv_wdata = fdata;
            if (i_req_kind == REQ_HREAD) begin
              d.drv_cmd = DRV_READ;
            end else if (in_range(comm, COMM_CMD, COMM_RAM_LAST)) begin
              d.drv_cmd = DRV_WRITE_RAM;
            end else begin
              d.drv_cmd = DRV_WRITE_EE;
            end
          end
        end
      end
      ST_DRIVE: begin
        if (i_drv_done) begin
          d.state     = ST_IDLE;
          d.rsp_valid = 1'b1;
          d.rsp_exc   = EXC_NONE;
          slot        = cache_slot(q.drv_comm);
          if (i_drv_err) begin
            d.rsp_data = '0;
            // drive refuses a frequency over max_frequency_limit or
            // upper_limit_frequency but the master still sees success
            if (!(q.drv_cmd != DRV_READ && q.drv_comm == COMM_FREQ)) begin
              d.rsp_exc = EXC_VALUE;
            end
          end else begin
            d.rsp_data = (q.drv_cmd == DRV_READ) ? i_drv_rdata : q.req_wdata;
            if (slot != SLOT_NONE) begin
              d.cache[q.drv_sel][slot] = (q.drv_cmd == DRV_READ) ? i_drv_rdata : q.drv_wdata;
            end
          end
        end
      end
      default: d.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      q         <= '0;
      q.timeout <= TIMEOUT_DEF;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign o_req_ready     = (q.state == ST_IDLE);
  assign o_rsp_valid     = q.rsp_valid;
  assign o_rsp_data      = q.rsp_data;
  assign o_rsp_exc       = q.rsp_exc;
  assign o_drv_valid     = (q.state == ST_DRIVE);
  assign o_drv_sel       = q.drv_sel;
  assign o_drv_cmd       = q.drv_cmd;
  assign o_drv_comm      = q.drv_comm;
  assign o_drv_wdata     = q.drv_wdata;
  assign o_reinit        = q.reinit;
  assign o_timeout_ms    = q.timeout;
  assign o_resp_delay_ms = q.delay;
  assign o_action_a      = q.act[0];
  assign o_action_b      = q.act[1];
  // a stored speed is inert unless the action asks for it
  assign o_preset_a      = (q.act[0] == ACT_PRESET) ? q.spd[0] : 4'h0;
  assign o_preset_b      = (q.act[1] == ACT_PRESET) ? q.spd[1] : 4'h0;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_low_half_a: assert property (o_drv_valid && q.req_kind[1] == 1'b0 && !q.eff[15]
    |-> !o_drv_sel) else $error("lower half not sent to drive A");
  a_high_half_b: assert property (o_drv_valid && q.req_kind[1] == 1'b0 && q.eff[15]
    |-> o_drv_sel) else $error("upper half not sent to drive B");
  a_a_high_comm: assert property (o_drv_valid && q.req_kind[1] == 1'b0 && !q.eff[15]
    && q.eff >= A_HIGH_LO |-> o_drv_comm == (q.eff | HALF_BIT))
    else $error("drive A high number wrong");
  a_b_low_comm: assert property (o_drv_valid && q.req_kind[1] == 1'b0 && q.eff[15]
    && q.eff < B_DIRECT_LO |-> o_drv_comm == (q.eff & HALF_MASK))
    else $error("drive B low number wrong");
  a_b_direct_comm: assert property (o_drv_valid && q.req_kind[1] == 1'b0
    && q.eff >= B_DIRECT_LO |-> o_drv_comm == q.eff) else $error("drive B direct wrong");
  a_ram_only_cmd: assert property (o_drv_valid && o_drv_cmd != DRV_READ
    && in_range(o_drv_comm, COMM_CMD, COMM_RAM_LAST) |-> o_drv_cmd == DRV_WRITE_RAM)
    else $error("command register not RAM-only");
  a_freq_acked: assert property (o_drv_valid && i_drv_done && i_drv_err
    && o_drv_cmd != DRV_READ && o_drv_comm == COMM_FREQ
    |=> o_rsp_valid && o_rsp_exc == EXC_NONE) else $error("frequency write not acked");
  a_reinit_zero: assert property (o_rsp_valid && q.req_kind == REQ_HREAD
    && q.eff == REG_REINIT |-> o_rsp_data == 16'h0000) else $error("reinit read not zero");
  a_ptr_reject: assert property (o_rsp_valid && q.req_kind == REQ_HWRITE
    && in_range(q.eff, PTR_ADDR_BASE, PTR_ADDR_LAST) && ptr_forbidden(q.req_wdata)
    && {1'b0, q.eff[4:0]} < 6'(PTR_COUNT)
    |-> o_rsp_exc == EXC_VALUE && o_rsp_data == 16'h0000) else $error("pointer not refused");
  a_timeout_keep: assert property (o_rsp_valid && q.req_kind == REQ_HWRITE
    && q.eff == REG_TIMEOUT && !in_range(q.req_wdata, TIMEOUT_MIN, TIMEOUT_MAX)
    |-> o_rsp_exc == EXC_VALUE && o_timeout_ms == $past(o_timeout_ms))
    else $error("bad timeout accepted");
  a_link_coil: assert property (o_rsp_valid && q.req_kind == REQ_CREAD
    && q.req_addr == RCOIL_LINK_A |-> o_rsp_data[0] == $past(w_online[0]))
    else $error("link coil wrong");
  a_drv_hold: assert property (o_drv_valid && !i_drv_done
    |=> o_drv_valid && $stable(o_drv_comm) && $stable(o_drv_cmd))
    else $error("drive request dropped");
  a_preset_gate: assert property (o_preset_b != 4'h0 |-> o_action_b == ACT_PRESET)
    else $error("drive B preset leaked");

  c_drive_write: cover property (o_drv_valid && o_drv_cmd == DRV_WRITE_EE ##[1:20] o_rsp_valid);
  c_ptr_read: cover property (i_req_valid && o_req_ready && w_pdata ##[1:20] o_rsp_valid);
  c_offline_hit: cover property (o_rsp_valid && o_rsp_exc == EXC_FAIL);
  c_coil_write: cover property (o_drv_valid && o_drv_cmd == DRV_WRITE_RAM);

endmodule : ddm_mapper

`default_nettype wire

// [tb/ddm_drive_model.sv]
`timescale 1ns/10ps
`default_nettype none

module ddm_drive_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_valid,
  input  wire logic [15:0] i_comm,
  input  wire logic [15:0] i_wdata,
  output logic             o_done,
  output logic [15:0]      o_rdata,
  output logic             o_err
);
  // ==========================================================
  // drive answer, four cycles after the command appears
  logic [2:0] wait_q;

  // read data is inverted outside done so stale values never match
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wait_q  <= 3'h0;
      o_done  <= 1'b0;
      o_rdata <= 16'h0000;
      o_err   <= 1'b0;
    end else begin
      o_done  <= i_valid && !o_done && wait_q == 3'h3;
      wait_q  <= (i_valid && !o_done) ? wait_q + 3'h1 : 3'h0;
      o_rdata <= (wait_q == 3'h3) ? (i_comm ^ 16'h00a5) : ~o_rdata;
      o_err   <= (wait_q == 3'h3) && i_wdata == 16'hffff;
    end
  end
endmodule : ddm_drive_model

`default_nettype wire

// [tb/dual_drive_modbus_register_mapper_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_total++; $display("ERROR %s exp %h got %h", n, e, a); end end

module dual_drive_modbus_register_mapper_tb;
  import ddm_pkg::*;
  logic         clk, rst, rv, rdy, rspv, dv, sel_o, done, derr, reinit, dsel;
  ddm_req_t     kind;
  ddm_drv_cmd_t cmd_o, dcmd;
  ddm_act_t     act_a, act_b;
  logic [15:0]  addr, wd, rdat, comm_o, wdat_o, drd, tmo, dly, rd, dcomm, dwd;
  logic [7:0]   exc_o, rexc;
  logic [1:0]   online;
  logic [3:0]   pre_a, pre_b;
  int           err_total, num_checks;

  ddm_mapper dut (.i_clk(clk), .i_reset(rst), .i_req_valid(rv), .i_req_kind(kind),
    .i_req_addr(addr), .i_req_wdata(wd), .o_req_ready(rdy), .o_rsp_valid(rspv),
    .o_rsp_data(rdat), .o_rsp_exc(exc_o), .o_drv_valid(dv), .o_drv_sel(sel_o),
    .o_drv_cmd(cmd_o), .o_drv_comm(comm_o), .o_drv_wdata(wdat_o), .i_drv_done(done),
    .i_drv_rdata(drd), .i_drv_err(derr), .i_drv_online(online), .o_reinit(reinit),
    .o_timeout_ms(tmo), .o_resp_delay_ms(dly), .o_action_a(act_a), .o_action_b(act_b),
    .o_preset_a(pre_a), .o_preset_b(pre_b));
  ddm_drive_model drv (.i_clk(clk), .i_reset(rst), .i_valid(dv), .i_comm(comm_o),
    .i_wdata(wdat_o), .o_done(done), .o_rdata(drd), .o_err(derr));

  // ==========================================================
  // one request, taken at once since ready stands in idle
  task automatic req(input ddm_req_t k, input logic [15:0] a, input logic [15:0] w);
    int n;
    n = 0;
    dsel = 1'bx;
    dcomm = 16'hxxxx;
    dwd = 16'hxxxx;
    dcmd = ddm_drv_cmd_t'(2'bxx);
    rv = 1'b1; kind = k; addr = a; wd = w;
    @(posedge clk); #1;
    rv = 1'b0;
    while (rspv !== 1'b1 && n < 60) begin
      if (dv === 1'b1) begin dsel = sel_o; dcomm = comm_o; dcmd = cmd_o; dwd = wdat_o; end
      @(posedge clk); #1;
      n++;
    end
    if (n == 60) err_total++;
    rd = rdat;
    rexc = exc_o;
  endtask : req

  task automatic t_local;
    req(REQ_HREAD, 16'h6100, 16'h0); `CHK("timeout", TIMEOUT_DEF, rd)
    req(REQ_HREAD, 16'h6111, 16'h0); `CHK("reinit rd", 16'h0000, rd)
    req(REQ_HREAD, 16'h0600, 16'h0); `CHK("hole", EXC_ADDR, rexc)
    req(REQ_HWRITE, 16'h6101, 16'h4);
    req(REQ_HWRITE, 16'h6102, 16'h9); `CHK("act a", ACT_PRESET, act_a)
    `CHK("preset a", 4'h9, pre_a)
    req(REQ_HWRITE, 16'h6110, 16'h07d1); `CHK("delay", EXC_VALUE, rexc)
    `CHK("delay hold", 16'h0000, dly)
    req(REQ_HWRITE, 16'he101, 16'h4);
    req(REQ_HWRITE, 16'he102, 16'h3); `CHK("preset b", 4'h3, pre_b)
    req(REQ_HWRITE, 16'h6111, KEY_RESET); `CHK("reinit", 1'b1, reinit)
    `CHK("keep act", ACT_PRESET, act_a)
    req(REQ_HWRITE, 16'h6111, KEY_DEFAULTS); `CHK("restore", ACT_NONE, act_b)
    `CHK("preset off", 4'h0, pre_a)
  endtask : t_local

  task automatic t_offline;
    req(REQ_HREAD, 16'h0011, 16'h0); `CHK("offline", EXC_FAIL, rexc)
    online = 2'b11;
    repeat (6) @(posedge clk);
    #1;
    req(REQ_CREAD, 16'h0073, 16'h0); `CHK("link a", 1'b1, rd[0])
  endtask : t_offline

  task automatic t_route;
    req(REQ_HWRITE, 16'h7a00, 16'h8000); `CHK("a comm", 16'hfa00, dcomm)
    `CHK("ram cmd", DRV_WRITE_RAM, dcmd)
    `CHK("a sel", 1'b0, dsel)
    req(REQ_HREAD, 16'h8010, 16'h0); `CHK("b comm", 16'h0010, dcomm)
    `CHK("b data", 16'h00b5, rd)
    req(REQ_HREAD, 16'hfe10, 16'h0); `CHK("b high", 16'hfe10, dcomm)
    req(REQ_HWRITE, 16'h0011, 16'hffff); `CHK("bad val", EXC_VALUE, rexc)
    `CHK("ee cmd", DRV_WRITE_EE, dcmd)
    req(REQ_HWRITE, 16'h7a01, 16'hffff); `CHK("freq ack", EXC_NONE, rexc)
  endtask : t_route

  task automatic t_ptr;
    req(REQ_HWRITE, 16'h6000, 16'h6085); `CHK("ptr rej", EXC_VALUE, rexc)
    req(REQ_HWRITE, 16'h6001, 16'h7e04);
    req(REQ_HREAD, 16'h6081, 16'h0); `CHK("ptr comm", 16'hfe04, dcomm)
    `CHK("ptr data", 16'hfea1, rd)
  endtask : t_ptr

  task automatic t_coil;
    req(REQ_CWRITE, 16'h000a, 16'h1234); `CHK("coil val", EXC_VALUE, rexc)
    req(REQ_CWRITE, 16'h0010, COIL_ON); `CHK("coil comm", 16'hfa00, dcomm)
    `CHK("coil sel", 1'b1, dsel)
    `CHK("coil word", 16'h0001, dwd)
    online = 2'b00;
    repeat (6) @(posedge clk);
    #1;
    req(REQ_HREAD, 16'h7a00, 16'h0); `CHK("cached", 16'h8000, rd)
    req(REQ_CREAD, 16'h0083, 16'h0); `CHK("link b", 1'b0, rd[0])
  endtask : t_coil

  task automatic give_verdict;
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100000;
    err_total++;
    give_verdict();
  end

  initial begin
    rst = 1'b1; rv = 1'b0; kind = REQ_HREAD; addr = 16'h0; wd = 16'h0; online = 2'b00;
    err_total = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    t_local();
    t_offline();
    t_route();
    t_ptr();
    t_coil();
    give_verdict();
  end
endmodule : dual_drive_modbus_register_mapper_tb

`default_nettype wire
